// ### verification/epd_phy_model.sv
`timescale 1ns/1ns
module epd_phy_model (
  // Management pins of the block.
  input  wire logic mdc,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n,
  output logic      mdio_in,
  // Link state commanded by the bench.
  input  wire logic link_up
);
  int          k = 99;
  logic [15:0] stat;

  // Bit count from the moment the block releases the line.
  always @(posedge mdio_oe_n) k = 0;
  always @(negedge mdc) if (mdio_oe_n) k = k + 1;

  // Status word with only the link flag, so any other bit read back is a fault.
  assign stat = {13'h0000, link_up, 2'b00};

  // The line is pulled up, so released bits other than the turnaround zero and the status bits read one, never a stale value.
  always_comb
    if (!mdio_oe_n) mdio_in = mdio_out;
    else if (k == 1) mdio_in = 1'b0;
    else if (k >= 2 && k <= 17) mdio_in = stat[17 - k];
    else mdio_in = 1'b1;
endmodule // epd_phy_model

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // Stimulus, responses and bookkeeping.
  logic             hclk = 1'b0;
  logic             hresetn = 1'b0;
  logic             global_cold_rst = 1'b0;
  logic             global_warm_rst = 1'b0;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0000_0000;
  logic [1:0]       htrans = 2'b00;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0000_0000;
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             hresp;
  epd_pkg::epd_rx_s rx = '0;
  logic             mdc;
  logic             mdio_in;
  logic             mdio_out;
  logic             mdio_oe_n;
  logic             link_up = 1'b0;
  logic             protocol_irq;
  logic             cold_req;
  logic             warm_req;
  int               n_fail = 0;
  int               comparisons = 0;
  int               cyc = 0;
  int               irq_q[$];
  logic [7:0]       fr[$];
  localparam logic [15:0] TY[7] = '{16'h88AE, 16'h8892, 16'h88CD, 16'h88AB, 16'h8000, 16'h8000, 16'h1234};
  localparam logic [23:0] OUI[7] = '{24'h02_0010, 24'h02_0010, 24'h02_0010, 24'h02_0010, 24'h02_0010,
                                      24'h02_0100, 24'h02_0010};
  localparam logic [7:0]  CD[7] = '{epd_pkg::CODE_PROTO1, epd_pkg::CODE_PROTO2, epd_pkg::CODE_PROTO3,
                                    epd_pkg::CODE_PROTO4, epd_pkg::CODE_IP, epd_pkg::CODE_NONE, epd_pkg::CODE_NONE};

  epd_detector #(.POLL_CYCLES(20)) epd_detector_inst (
    .hclk(hclk), .hresetn(hresetn), .global_cold_rst(global_cold_rst), .global_warm_rst(global_warm_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx(rx), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .protocol_irq(protocol_irq),
    .sw_cold_reset_request(cold_req), .sw_warm_reset_request(warm_req));
  epd_phy_model epd_phy_model_inst (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdio_in(mdio_in),
    .link_up(link_up));

  // Free-running clock and an edge counter for latency checks.
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single transfer; the answer time is not assumed, only hready decides.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    check("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
    logic [31:0] r;
    bus(1'b0, a, 32'($urandom), r);
    check(n, e & m, r & m);
  endtask

  task automatic pulse(input logic cold);
    global_cold_rst <= cold;
    global_warm_rst <= !cold;
    @(posedge hclk);
    global_cold_rst <= 1'b0;
    global_warm_rst <= 1'b0;
    @(posedge hclk);
  endtask

  // Header, then n stored bytes; the irq is noted four edges after the last byte is put on.
  task automatic send(input logic [15:0] ty, input logic [23:0] oui, input int n, input logic hit);
    logic [7:0] b;
    fr.delete();
    for (int i = 0; i < n; i++)
    begin
      b = (i > 5 && i < 9) ? oui[(8 - i) * 8 +: 8] : (i == 12) ? ty[15:8] : (i == 13) ? ty[7:0] : 8'($urandom);
      fr.push_back(b);
    end
    for (int i = 0; i < n + 8; i++)
    begin
      rx <= {1'b1, 1'(i == n + 7), (i < 7) ? 8'h55 : (i == 7) ? 8'hD5 : fr[i - 8]};
      if (i == n + 7 && hit) irq_q.push_back(cyc + 4);
      @(posedge hclk);
    end
    repeat (2)
    begin
      rx <= {2'b00, 8'($urandom)};
      @(posedge hclk);
    end
  endtask

  // Every irq pulse must match the oldest noted frame.
  always @(posedge hclk)
    if (protocol_irq === 1'b1)
    begin
      if (irq_q.size() == 0) check("irq_extra", 32'h0, 32'h1);
      else check("irq_cycle", irq_q.pop_front(), cyc);
    end

  // A hang counts as a mismatch and ends the run in the usual place.
  initial
  begin
    repeat (30000) @(posedge hclk);
    n_fail++;
    $display("FAIL watchdog expected done seen timeout");
    test_done();
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] cd;
    void'($urandom(44996));
    cd = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(epd_pkg::RST_CTRL_ADDR, 32'h0, '1, "rst_ctrl");
    wr(epd_pkg::RST_CTRL_ADDR + 32'h4, 32'h3);
    check("req_other_addr", 32'h0, 32'({cold_req, warm_req}));
    // No memory traffic is pending here, which stands for memory parked in self-refresh.
    wr(epd_pkg::RST_CTRL_ADDR, 32'h2);
    check("req_cold", 32'h2, 32'({cold_req, warm_req}));
    rd(epd_pkg::RST_CTRL_ADDR, 32'h0, '1, "rst_ctrl_cold");
    pulse(1'b0);
    check("cold_after_warm", 32'h1, 32'(cold_req));
    pulse(1'b1);
    check("cold_after_cold", 32'h0, 32'(cold_req));
    wr(epd_pkg::RST_CTRL_ADDR, 32'h1);
    check("req_warm", 32'h1, 32'({cold_req, warm_req}));
    rd(epd_pkg::RST_CTRL_ADDR, 32'h0, '1, "rst_ctrl_warm");
    pulse(1'b0);
    check("warm_after_warm", 32'h0, 32'(warm_req));
    wr(epd_pkg::RST_CTRL_ADDR, 32'h1);
    pulse(1'b1);
    check("warm_after_cold", 32'h0, 32'(warm_req));
    r = $urandom;
    wr(epd_pkg::SCRATCH_ADDR, r);
    pulse(1'b1);
    pulse(1'b0);
    rd(epd_pkg::SCRATCH_ADDR, r, '1, "scratch");
    wr(epd_pkg::SCRATCH_ADDR, 32'h0000_0000);
    rd(epd_pkg::SCRATCH_ADDR, 32'h0000_0000, '1, "scratch_clear");
    rd(32'h0000_3000, 32'h0, '1, "unmapped");
    rd(epd_pkg::STATUS_ADDR, 32'h0, 32'h1, "link_down");
    send(TY[0], OUI[0], 20, 1'b0);
    link_up <= 1'b1;
    r = 32'h0;
    // Two whole management polls and the gap bound the wait, so a missing link report trips the check.
    for (int i = 0; i < 2000 && r[0] !== 1'b1; i++) bus(1'b0, epd_pkg::STATUS_ADDR, 32'h0, r);
    check("link_up", 32'h1, 32'(r[0]));
    for (int t = 0; t < 7; t++)
    begin
      send(TY[t], OUI[t], 20 + t, CD[t] != 8'h00);
      repeat (4) @(posedge hclk);
      if (CD[t] != 8'h00) cd = 32'(CD[t]);
      rd(epd_pkg::CODE_ADDR, cd, 32'h0000_00FF, "code");
      if (t == 0) rd(32'h0, {fr[3], fr[2], fr[1], fr[0]}, '1, "ram0");
      if (t == 0) rd(32'hC, {fr[15], fr[14], fr[13], fr[12]}, '1, "ram12");
      if (t == 0) rd(epd_pkg::STATUS_ADDR, (32'h0000_0014 << epd_pkg::STAT_LEN_LSB) | 32'h0000_0001, '1, "status_len");
    end
    send(TY[1], OUI[1], 14, 1'b1);
    send(TY[2], OUI[2], 30, 1'b1);
    send(TY[0], OUI[0], 13, 1'b0);
    // A parked detector drops its link flag, so a known frame must pass unreported.
    wr(epd_pkg::CTRL_ADDR, 32'h0000_0000);
    send(TY[0], OUI[0], 20, 1'b0);
    repeat (8) @(posedge hclk);
    rd(epd_pkg::CODE_ADDR, 32'(CD[2]), 32'h0000_00FF, "code_last");
    check("irq_missing", 32'h0, 32'(irq_q.size()));
    test_done();
  end
endmodule // tb_top

// ### verilog/epd_detector.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
// Summary of operation
// - Writing one to the cold bit requests a cold reset; reads return zero.
// - The cold request bit clears only on a cold reset, never a warm one.
// - Writing one to the warm bit requests a warm reset; reads return zero.
// - The warm request bit clears on any warm or cold reset.
// - The reset control register decodes at address 0x44E00F00.
// - Poll the PHY over management until it reports link before awaiting frames.
// - With link up, wait for a new frame and store its bytes.
// - After the whole frame, classify from the two type bytes at offset 12.
// - Type 0x88AE is the first supported protocol.
// - Type compare constants are byte-swapped, 0x88AE checked as 0xAE88.
// - Store the detected code locally, then raise an interrupt to the host.
// - After the interrupt, return to waiting for the next frame.
// - Keep the frame in local RAM from address zero, up to RAM_BYTES bytes.
// - Strip the eight header bytes so storage starts at destination address.
// - Types 0x8892, 0x88CD and 0x88AB are three further protocols with codes.
// - Type 0x8000 counts only if the source address is in vendor range.
// - The scratch code survives software cold and warm resets.
module epd_detector #(
  parameter int          RAM_BYTES     = 2048,
  parameter int          POLL_CYCLES   = epd_pkg::POLL_GAP_CYC,
  parameter logic [23:0] VENDOR_OUI_LO = 24'h02_0000, // Arbitrary value.
  parameter logic [23:0] VENDOR_OUI_HI = 24'h02_00FF  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Global reset sources seen by this block, one cycle each.
  input  wire logic             global_cold_rst,
  input  wire logic             global_warm_rst,
  // AHB-Lite slave.
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Receive path, header bytes still present.
  input  wire epd_pkg::epd_rx_s rx,
  // PHY management pins.
  output logic                  mdc,
  input  wire logic             mdio_in,
  output logic                  mdio_out,
  output logic                  mdio_oe_n,
  // Host interrupt and global software reset requests.
  output logic                  protocol_irq,
  output logic                  sw_cold_reset_request,
  output logic                  sw_warm_reset_request
);

  localparam int AW = $clog2(RAM_BYTES);

  logic [7:0]          frame_mem [RAM_BYTES];
  epd_pkg::epd_state_e state_reg;
  logic                soft_rst;
  logic                ahb_go;
  logic                dp_pend_reg;
  logic [31:0]         dp_addr_reg;
  logic                dp_write_reg;
  logic                wr_rst_ctrl;
  logic [31:0]         rd_word;
  logic [31:0]         ctrl_reg;
  logic [31:0]         scratch_reg;
  logic [7:0]          code_reg;
  logic                cold_req_reg;
  logic                warm_req_reg;
  logic                hresp_reg;
  logic                irq_reg;
  logic                link_up_reg;
  logic [AW:0]         len_reg;
  logic [3:0]          pre_cnt_reg;
  logic [7:0]          match_code;
  logic                mdio_meta_reg;
  logic                mdio_sync_reg;
  logic                mdc_reg;
  logic                mdio_out_reg;
  logic                mdio_oe_n_reg;
  logic [7:0]          div_cnt_reg;
  logic [6:0]          bit_cnt_reg;
  logic [15:0]         rd_shift_reg;
  logic [31:0]         poll_cnt_reg;
  logic                mdc_tick;
  logic                mdc_fall;
  logic                mdc_rise;
  logic [63:0]         mdio_frame;

  // A software reset of either kind restarts the detector; software may also park it.
  assign soft_rst    = global_cold_rst | global_warm_rst;
  assign ahb_go      = hsel & htrans[1] & hready & hreadyout;
  assign wr_rst_ctrl = dp_pend_reg & dp_write_reg & (dp_addr_reg == epd_pkg::RST_CTRL_ADDR);

  // Out-of-range byte indices read as zero rather than wrapping into the frame.
  function automatic logic [7:0] rd_byte(input logic [31:0] idx);
    if (idx < 32'(RAM_BYTES))
      return frame_mem[idx[AW-1:0]];
    else
      return 8'h00;
  endfunction

  // Maps the stored type field and source vendor prefix to a protocol code.
  function automatic logic [7:0] classify(input logic [15:0] typ, input logic [23:0] oui);
    case (typ)
      epd_pkg::TYPE_PROTO1: return epd_pkg::CODE_PROTO1;
      epd_pkg::TYPE_PROTO2: return epd_pkg::CODE_PROTO2;
      epd_pkg::TYPE_PROTO3: return epd_pkg::CODE_PROTO3;
      epd_pkg::TYPE_PROTO4: return epd_pkg::CODE_PROTO4;
      epd_pkg::TYPE_IP:
        if (oui >= VENDOR_OUI_LO && oui <= VENDOR_OUI_HI)
          return epd_pkg::CODE_IP;
        else
          return epd_pkg::CODE_NONE;
      default: return epd_pkg::CODE_NONE;
    endcase
  endfunction

  // The type pair is read high byte at offset 13, which gives the swapped form.
  always_comb
  begin
    match_code = epd_pkg::CODE_NONE;
    if (len_reg >= (AW+1)'(epd_pkg::MIN_FRAME))
      match_code = classify({rd_byte(32'(epd_pkg::TYPE_OFS + 1)), rd_byte(32'(epd_pkg::TYPE_OFS))},
                            {rd_byte(32'(epd_pkg::SRC_OFS)), rd_byte(32'(epd_pkg::SRC_OFS + 1)),
                             rd_byte(32'(epd_pkg::SRC_OFS + 2))});
  end

  // Bus read multiplexer; request bits and unmapped space read as zero.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (dp_addr_reg < epd_pkg::FRAME_WINDOW)
      rd_word = {rd_byte(dp_addr_reg + 32'h0000_0003), rd_byte(dp_addr_reg + 32'h0000_0002),
                 rd_byte(dp_addr_reg + 32'h0000_0001), rd_byte(dp_addr_reg)};
    else if (dp_addr_reg == epd_pkg::CODE_ADDR)
      rd_word = {24'h00_0000, code_reg};
    else if (dp_addr_reg == epd_pkg::STATUS_ADDR)
    begin
      rd_word[epd_pkg::STAT_LINK_BIT] = link_up_reg;
      rd_word[epd_pkg::STAT_BUSY_BIT] = (state_reg == epd_pkg::ST_RECV);
      rd_word[epd_pkg::STAT_LEN_LSB +: AW+1] = len_reg;
    end
    else if (dp_addr_reg == epd_pkg::CTRL_ADDR)
      rd_word = ctrl_reg;
    else if (dp_addr_reg == epd_pkg::SCRATCH_ADDR)
      rd_word = scratch_reg;
  end

  // Every transfer takes one wait state so read data can come from a flip-flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_pend_reg  <= 1'b0;
      dp_addr_reg  <= 32'h0000_0000;
      dp_write_reg <= 1'b0;
      hrdata       <= 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp_reg    <= 1'b0;
    end
    else if (ahb_go)
    begin
      dp_pend_reg  <= 1'b1;
      dp_addr_reg  <= haddr;
      dp_write_reg <= hwrite;
      hreadyout    <= 1'b0;
    end
    else if (dp_pend_reg)
    begin
      dp_pend_reg <= 1'b0;
      hreadyout   <= 1'b1;
      hrdata      <= dp_write_reg ? 32'h0000_0000 : rd_word;
    end
  end

  assign hresp = hresp_reg;

  // Cold requests hold until a cold reset acts, warm requests until any software reset acts.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cold_req_reg <= 1'b0;
      warm_req_reg <= 1'b0;
    end
    else
    begin
      if (wr_rst_ctrl && hwdata[epd_pkg::COLD_BIT])
        cold_req_reg <= 1'b1;
      else if (global_cold_rst)
        cold_req_reg <= 1'b0;
      if (wr_rst_ctrl && hwdata[epd_pkg::WARM_BIT])
        warm_req_reg <= 1'b1;
      else if (soft_rst)
        warm_req_reg <= 1'b0;
    end
  end

  assign sw_cold_reset_request = cold_req_reg;
  assign sw_warm_reset_request = warm_req_reg;

  // Scratch is cleared only by the power-on reset so the bootloader can read it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      scratch_reg <= 32'h0000_0000;
    else if (dp_pend_reg && dp_write_reg && dp_addr_reg == epd_pkg::SCRATCH_ADDR)
      scratch_reg <= hwdata;
  end

  // Control register: enable and PHY address, restored by any reset.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= epd_pkg::CTRL_RESET;
    else if (soft_rst)
      ctrl_reg <= epd_pkg::CTRL_RESET;
    else if (dp_pend_reg && dp_write_reg && dp_addr_reg == epd_pkg::CTRL_ADDR)
      ctrl_reg <= hwdata;
  end

  // Management input passes two flip-flops before any use.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mdio_meta_reg <= 1'b1;
      mdio_sync_reg <= 1'b1;
    end
    else
    begin
      mdio_meta_reg <= mdio_in;
      mdio_sync_reg <= mdio_meta_reg;
    end
  end

  // Read of the PHY status register; turnaround and data bits are released.
  assign mdio_frame = {32'hFFFF_FFFF, 2'b01, 2'b10, ctrl_reg[epd_pkg::CTRL_PHY_LSB +: 5],
                       epd_pkg::PHY_STATUS_REG, 2'b11, 16'hFFFF};
  assign mdc_tick   = (state_reg == epd_pkg::ST_MDIO) && (div_cnt_reg == 8'(epd_pkg::MDC_HALF_CYC - 1));
  assign mdc_fall   = mdc_tick & mdc_reg;
  assign mdc_rise   = mdc_tick & ~mdc_reg;

  // Clock divider and bit sequencer; data shifts out after each falling edge.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt_reg   <= 8'h00;
      mdc_reg       <= 1'b0;
      bit_cnt_reg   <= 7'h00;
      rd_shift_reg  <= 16'h0000;
      mdio_out_reg  <= 1'b1;
      mdio_oe_n_reg <= 1'b1;
    end
    else if (state_reg != epd_pkg::ST_MDIO)
    begin
      div_cnt_reg   <= 8'h00;
      mdc_reg       <= 1'b0;
      bit_cnt_reg   <= 7'h00;
      mdio_out_reg  <= 1'b1;
      mdio_oe_n_reg <= 1'b1;
    end
    else
    begin
      div_cnt_reg   <= mdc_tick ? 8'h00 : div_cnt_reg + 8'h01;
      mdc_reg       <= mdc_tick ? ~mdc_reg : mdc_reg;
      mdio_out_reg  <= mdio_frame[6'(epd_pkg::MDIO_BITS - 1) - bit_cnt_reg[5:0]];
      mdio_oe_n_reg <= (bit_cnt_reg >= 7'(epd_pkg::MDIO_TA_START));
      if (mdc_fall)
        bit_cnt_reg <= bit_cnt_reg + 7'h01;
      if (mdc_rise && bit_cnt_reg >= 7'(epd_pkg::MDIO_DATA_START))
        rd_shift_reg <= {rd_shift_reg[14:0], mdio_sync_reg};
    end
  end

  assign mdc       = mdc_reg;
  assign mdio_out  = mdio_out_reg;
  assign mdio_oe_n = mdio_oe_n_reg;

  // Main sequence: link poll, receive, classify, report.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg    <= epd_pkg::ST_IDLE;
      link_up_reg  <= 1'b0;
      poll_cnt_reg <= 32'h0000_0000;
      pre_cnt_reg  <= 4'h0;
      len_reg      <= '0;
      code_reg     <= epd_pkg::CODE_NONE;
      irq_reg      <= 1'b0;
    end
    else if (soft_rst || !ctrl_reg[epd_pkg::CTRL_EN_BIT])
    begin
      state_reg   <= epd_pkg::ST_IDLE;
      link_up_reg <= 1'b0;
      irq_reg     <= 1'b0;
      if (soft_rst)
        code_reg <= epd_pkg::CODE_NONE;
    end
    else
    begin
      irq_reg <= 1'b0;
      case (state_reg)
        epd_pkg::ST_IDLE:
          state_reg <= epd_pkg::ST_MDIO;
        epd_pkg::ST_MDIO:
          if (mdc_fall && bit_cnt_reg == 7'(epd_pkg::MDIO_BITS - 1))
          begin
            poll_cnt_reg <= 32'h0000_0000;
            if (rd_shift_reg[epd_pkg::PHY_LINK_BIT])
            begin
              link_up_reg <= 1'b1;
              state_reg   <= epd_pkg::ST_WAIT;
            end
            else
              state_reg <= epd_pkg::ST_POLL_GAP;
          end
        epd_pkg::ST_POLL_GAP:
          if (poll_cnt_reg == 32'(POLL_CYCLES - 1))
            state_reg <= epd_pkg::ST_MDIO;
          else
            poll_cnt_reg <= poll_cnt_reg + 32'h0000_0001;
        epd_pkg::ST_WAIT:
          if (rx.valid && !rx.last)
          begin
            pre_cnt_reg <= 4'h1;
            len_reg     <= '0;
            state_reg   <= epd_pkg::ST_RECV;
          end
        epd_pkg::ST_RECV:
          if (rx.valid)
          begin
            if (pre_cnt_reg < 4'(epd_pkg::PREAMBLE_BYTES))
              pre_cnt_reg <= pre_cnt_reg + 4'h1;
            else if (len_reg < (AW+1)'(RAM_BYTES))
              len_reg <= len_reg + (AW+1)'(1);
            if (rx.last)
              state_reg <= epd_pkg::ST_CLASSIFY;
          end
        epd_pkg::ST_CLASSIFY:
          if (match_code != epd_pkg::CODE_NONE)
          begin
            code_reg  <= match_code;
            state_reg <= epd_pkg::ST_REPORT;
          end
          else
            state_reg <= epd_pkg::ST_WAIT;
        epd_pkg::ST_REPORT:
        begin
          irq_reg   <= 1'b1;
          state_reg <= epd_pkg::ST_WAIT;
        end
        default:
          state_reg <= epd_pkg::ST_IDLE;
      endcase
    end
  end

  assign protocol_irq = irq_reg;

  // Frame store; bytes beyond the RAM are dropped, the frame starts at zero.
  always_ff @(posedge hclk)
  begin
    if (state_reg == epd_pkg::ST_RECV && rx.valid && pre_cnt_reg >= 4'(epd_pkg::PREAMBLE_BYTES)
        && len_reg < (AW+1)'(RAM_BYTES))
      frame_mem[len_reg[AW-1:0]] <= rx.data;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_report;
    (state_reg == epd_pkg::ST_REPORT) ##1 (protocol_irq && state_reg == epd_pkg::ST_WAIT);
  endsequence

  property p_rst_ctrl_reads_zero;
    dp_pend_reg && !dp_write_reg && dp_addr_reg == epd_pkg::RST_CTRL_ADDR |=> hreadyout && hrdata == 32'h0000_0000;
  endproperty
  a_rst_ctrl_reads_zero: assert property (p_rst_ctrl_reads_zero) else $error("reset control read not zero");

  property p_cold_set;
    wr_rst_ctrl && hwdata[epd_pkg::COLD_BIT] |=> sw_cold_reset_request;
  endproperty
  a_cold_set: assert property (p_cold_set) else $error("cold request not raised");

  property p_cold_kept_by_warm;
    sw_cold_reset_request && global_warm_rst && !global_cold_rst |=> sw_cold_reset_request;
  endproperty
  a_cold_kept_by_warm: assert property (p_cold_kept_by_warm) else $error("warm reset cleared cold request");

  property p_warm_clear;
    soft_rst && !(wr_rst_ctrl && hwdata[epd_pkg::WARM_BIT]) |=> !sw_warm_reset_request;
  endproperty
  a_warm_clear: assert property (p_warm_clear) else $error("warm request survived a reset");

  property p_wait_needs_link;
    state_reg == epd_pkg::ST_WAIT |-> link_up_reg;
  endproperty
  a_wait_needs_link: assert property (p_wait_needs_link) else $error("waiting for frames without link");

  property p_classify_after_last;
    state_reg == epd_pkg::ST_CLASSIFY |-> $past(state_reg == epd_pkg::ST_RECV && rx.valid && rx.last);
  endproperty
  a_classify_after_last: assert property (p_classify_after_last) else $error("classified before frame end");

  property p_match_reports;
    state_reg == epd_pkg::ST_CLASSIFY && match_code != epd_pkg::CODE_NONE && ctrl_reg[epd_pkg::CTRL_EN_BIT]
      && !soft_rst ##1 !soft_rst |-> s_report;
  endproperty
  a_match_reports: assert property (p_match_reports) else $error("known type not reported");

  property p_irq_has_code;
    protocol_irq |-> code_reg != epd_pkg::CODE_NONE;
  endproperty
  a_irq_has_code: assert property (p_irq_has_code) else $error("interrupt without protocol code");

  property p_unknown_silent;
    state_reg == epd_pkg::ST_CLASSIFY && match_code == epd_pkg::CODE_NONE |=> !protocol_irq [*2];
  endproperty
  a_unknown_silent: assert property (p_unknown_silent) else $error("interrupt for unknown type");

endmodule // epd_detector

// ### verilog/epd_pkg.sv
package epd_pkg;

  // System addresses of the software reset control and the scratch register.
  localparam logic [31:0] RST_CTRL_ADDR   = 32'h44E0_0F00;
  localparam logic [31:0] SCRATCH_ADDR    = 32'h44E3_E060;
  localparam int          COLD_BIT        = 1;
  localparam int          WARM_BIT        = 0;

  // Local window: frame bytes from the bottom, then detector registers.
  localparam logic [31:0] FRAME_BASE      = 32'h0000_0000;
  localparam logic [31:0] FRAME_WINDOW    = 32'h0000_2000;
  localparam logic [31:0] CODE_ADDR       = 32'h0000_2000;
  localparam logic [31:0] STATUS_ADDR     = 32'h0000_2004;
  localparam logic [31:0] CTRL_ADDR       = 32'h0000_2008;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_PHY_LSB    = 8;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
  localparam int          STAT_LINK_BIT   = 0;
  localparam int          STAT_BUSY_BIT   = 1;
  localparam int          STAT_LEN_LSB    = 16;

  // Header length, and frame layout after this block has stripped the header.
  localparam int          PREAMBLE_BYTES  = 8;
  localparam int          SRC_OFS         = 6;
  localparam int          TYPE_OFS        = 12;
  localparam int          MIN_FRAME       = 14;

  // Type values as held in the internal register, low byte first.
  localparam logic [15:0] TYPE_PROTO1     = 16'hAE88;
  localparam logic [15:0] TYPE_PROTO2     = 16'h9288;
  localparam logic [15:0] TYPE_PROTO3     = 16'hCD88;
  localparam logic [15:0] TYPE_PROTO4     = 16'hAB88;
  localparam logic [15:0] TYPE_IP         = 16'h0080;

  // Protocol codes written to local memory.
  localparam logic [7:0]  CODE_NONE       = 8'h00;
  localparam logic [7:0]  CODE_PROTO1     = 8'h01;
  localparam logic [7:0]  CODE_PROTO2     = 8'h02;
  localparam logic [7:0]  CODE_PROTO3     = 8'h03;
  localparam logic [7:0]  CODE_PROTO4     = 8'h04;
  localparam logic [7:0]  CODE_IP         = 8'h05;

  // Management read frame layout and the status register link flag.
  localparam int          MDIO_BITS       = 64;
  localparam int          MDIO_TA_START   = 46;
  localparam int          MDIO_DATA_START = 48;
  localparam logic [4:0]  PHY_STATUS_REG  = 5'h01;
  localparam int          PHY_LINK_BIT    = 2;

  // Timing figures and the cycle counts derived from them.
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          MDC_HALF_NS     = 200;
  localparam int          MDC_HALF_CYC    = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          POLL_GAP_US     = 1000;
  localparam int          POLL_GAP_CYC    = POLL_GAP_US * 1000 / CLK_PERIOD_NS;

  // One received byte from the receive path.
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } epd_rx_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MDIO,
    ST_POLL_GAP,
    ST_WAIT,
    ST_RECV,
    ST_CLASSIFY,
    ST_REPORT
  } epd_state_e;

endpackage
